// File: hw/rcdc_pkg.sv
// Package with register map, encodings and state records for the receive clock/decoder block
package rcdc_pkg;
   localparam logic [5:0] RCDC_ADDR_PRESET = 6'h1D;
   localparam logic [5:0] RCDC_ADDR_RXCTL  = 6'h1E;
   localparam logic [5:0] RCDC_ADDR_QCTL   = 6'h1F;
   localparam logic [7:0] RCDC_PRESET_RST  = 8'h00;
   localparam logic [7:0] RCDC_RXCTL_RST   = 8'h41;
   localparam logic [1:0] RCDC_QCTL_HI_RST = 2'h0;
   localparam logic [4:0] RCDC_TAPS_RST    = 5'h00;
   localparam int         RCDC_CLKSEL_BIT  = 7;
   localparam int         RCDC_AUTOPD_BIT  = 6;
   localparam int         RCDC_HALF_BIT    = 7;
   localparam int         RCDC_CALDIS_BIT  = 6;
   localparam int         RCDC_QRSV_BIT    = 5;
   localparam int         RCDC_TAPS_MSB    = 4;
   localparam int         RCDC_SRC_MSB     = 1;
   localparam int         RCDC_LINE_LEN    = 32;
   localparam logic [7:0] RCDC_PER_MAX     = 8'hFF;
   localparam logic [4:0] RCDC_TAPS_MAX    = 5'h1F;

   typedef enum logic [1:0] {
      SRC_LOW   = 2'h0,
      SRC_DEMOD = 2'h1,
      SRC_SUBC  = 2'h2,
      SRC_BASE  = 2'h3
   } rcdc_src_e;

   typedef enum logic [2:0] {
      RX_IDLE  = 3'h1,
      RX_GUARD = 3'h2,
      RX_RECV  = 3'h4
   } rcdc_rx_e;

   typedef enum logic [2:0] {
      CAL_IDLE = 3'h1,
      CAL_ARM  = 3'h2,
      CAL_MEAS = 3'h4
   } rcdc_cal_e;

   typedef struct packed {
      logic [7:0] preset;
      logic [7:0] rxctl;
      logic [1:0] qctl_hi;
      logic [4:0] taps;
      rcdc_rx_e   rx_st;
      logic [7:0] guard_cnt;
      logic       aux_s1;
      logic       aux_s2;
      logic       cal_pend;
      logic [7:0] rdata;
      logic       dec_data;
      logic       dec_subc;
      logic       rcv_clk;
      logic       rx_pwr;
   } rcdc_main_s;

   typedef struct packed {
      logic                     ic_s1;
      logic                     ic_s2;
      logic                     ic_prev;
      logic [RCDC_LINE_LEN-1:0] line;
      logic [7:0]               per_cnt;
      logic [7:0]               period;
      rcdc_cal_e                st;
      logic                     half;
      logic                     done;
      logic [4:0]               taps;
      logic                     qclk;
   } rcdc_cal_s;
endpackage

// File: hw/rcdc_qclk_cal.sv
// Quadrature clock delay line, period measurement and tap calibration
`timescale 1ns/1ns
module rcdc_qclk_cal
   import rcdc_pkg::*;
(
   input  wire logic       clk,        // Core clock
   input  wire logic       rst,        // Synchronous reset
   input  wire logic       iclk_pin,   // In-phase clock, asynchronous
   input  wire logic       cal_start,  // Start calibration pulse
   input  wire logic [4:0] taps,       // Taps in use
   output logic            iclk,       // Synchronised in-phase clock
   output logic            qclk,       // Delayed quadrature clock
   output logic            half_turn,  // Lag above half a period
   output logic            cal_done,   // Calibration result pulse
   output logic [4:0]      cal_taps    // Calibrated tap count
);
   rcdc_cal_s s_reg;
   rcdc_cal_s s_next;
   logic      rise;
   logic [5:0] quarter;

   assign rise    = s_reg.ic_s2 & ~s_reg.ic_prev;
   assign quarter = s_reg.per_cnt[7:2];

   always_comb begin
      s_next         = s_reg;
      s_next.ic_s1   = iclk_pin;
      s_next.ic_s2   = s_reg.ic_s1;
      s_next.ic_prev = s_reg.ic_s2;
      s_next.line    = {s_reg.line[RCDC_LINE_LEN-2:0], s_reg.ic_s2};
      s_next.qclk    = s_reg.line[taps];  // see R5
      s_next.done    = 1'b0;
      if (s_reg.per_cnt != RCDC_PER_MAX) begin
         s_next.per_cnt = s_reg.per_cnt + 8'h01;
      end
      if (rise) begin
         s_next.per_cnt = 8'h01;
         s_next.period  = s_reg.per_cnt;
      end
      // Lag of taps cycles exceeds half the period
      s_next.half = ({3'h0, taps, 1'b0} > {1'b0, s_reg.period});  // see R6
      case (s_reg.st)
         CAL_IDLE: begin
            if (cal_start) begin
               s_next.st = CAL_ARM;
            end
         end
         CAL_ARM: begin
            if (rise) begin
               s_next.st = CAL_MEAS;
            end else if (s_reg.per_cnt == RCDC_PER_MAX) begin
               s_next.st = CAL_MEAS;
            end
         end
         CAL_MEAS: begin
            // Saturated count ends a calibration with no clock present
            if (rise || s_reg.per_cnt == RCDC_PER_MAX) begin
               s_next.st   = CAL_IDLE;
               s_next.done = 1'b1;
               if (quarter > {1'b0, RCDC_TAPS_MAX}) begin
                  s_next.taps = RCDC_TAPS_MAX;
               end else if (quarter == 6'h00) begin
                  s_next.taps = 5'h01;
               end else begin
                  s_next.taps = quarter[4:0];
               end
            end
         end
         default: s_next.st = CAL_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_reg <= '{ic_s1: 1'b0, ic_s2: 1'b0, ic_prev: 1'b0, line: '0, per_cnt: 8'h00,
                    period: 8'h00, st: CAL_IDLE, half: 1'b0, done: 1'b0, taps: 5'h01,
                    qclk: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign iclk      = s_reg.ic_s2;
   assign qclk      = s_reg.qclk;
   assign half_turn = s_reg.half;
   assign cal_done  = s_reg.done;
   assign cal_taps  = s_reg.taps;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_qclk_delay;
      ##1 qclk == $past(s_reg.line[taps]);
   endproperty
   a_qclk_delay: assert property (p_qclk_delay)  // see R5
      else $error("quadrature clock not taken from selected tap");

   property p_done_taps;
      cal_done |-> cal_taps >= 5'h01;
   endproperty
   a_done_taps: assert property (p_done_taps)  // see R8
      else $error("calibration produced zero taps");
endmodule

// File: hw/rcdc_top.sv
// Receive clock select, decoder source, power sequencing and quadrature clock registers
// Contract
// R1: Clock select bit 1 picks in-phase clock for receiver; 0 picks quadrature.
// R2: Auto power-down 1 powers receiver only around reception; 0 keeps it on.
// R3: Source 00 feeds constant low; 01 feeds the internal demodulator.
// R4: Source 10 feeds subcarrier stream from aux pin; 11 baseband stream.
// R5: Quadrature clock is the in-phase clock delayed by a quarter turn.
// R6: Half-turn flag reads 1 when the quadrature lag exceeds half a period.
// R7: Calibration disable 0 recalibrates after reset and each card reception.
// R8: Tap field shows how many delay elements form the phase shift.
// R9: Host write or calibration may set taps; the latest one wins.
// R10: Host keeps the reserved bits of both control registers unchanged.
// R11: Host leaves the preset register at 1D untouched; resets to 00.
// R12: Receive control register resets to 41.
// R13: After transmit, receiver waits guard count bit clocks, ignoring input.
// R14: With auto power-down, power spans end of guard to end of frame.
`timescale 1ns/1ns
module rcdc_top
   import rcdc_pkg::*;
(
   input  wire logic       CORE_CLK,         // 25 MHz core clock
   input  wire logic       RST,              // Synchronous reset, active high
   input  wire logic [5:0] REG_ADDR,         // Register address
   input  wire logic [7:0] REG_WDATA,        // Write data
   input  wire logic       REG_WR,           // Write strobe
   input  wire logic       REG_RD,           // Read strobe
   output logic      [7:0] REG_RDATA,        // Read data, one cycle after strobe
   input  wire logic [7:0] GUARD_COUNT,      // Receive guard count in bit clocks
   input  wire logic       BIT_CLK_TICK,     // One pulse per bit clock
   input  wire logic       TX_DONE,          // Transmission finished pulse
   input  wire logic       RX_FRAME_END,     // Received frame finished pulse
   input  wire logic       DEMOD_IN,         // Internal demodulator data
   input  wire logic       AUX_SERIAL_IN,    // Auxiliary serial input pin
   input  wire logic       ICLK_IN,          // In-phase clock from pin
   output logic            RECEIVER_CLK,     // Selected receiver clock
   output logic            RECEIVER_POWER,   // Receiver circuit powered
   output logic            RX_ACTIVE,        // Receive input accepted
   output logic            DECODER_DATA,     // Decoder input stream
   output logic            DECODER_SUBCARR   // Stream is subcarrier coded
);
   rcdc_main_s s_reg;
   rcdc_main_s s_next;
   logic       iclk;
   logic       qclk;
   logic       half_turn;
   logic       cal_done;
   logic [4:0] cal_taps;
   logic       cal_start;
   logic       wr_qctl;
   rcdc_src_e  src;

   function automatic logic [7:0] qctl_view(input logic half, input logic [1:0] hi,
                                           input logic [4:0] tp);
      qctl_view = {half, hi, tp};
   endfunction

   assign src       = rcdc_src_e'(s_reg.rxctl[RCDC_SRC_MSB:0]);
   assign wr_qctl   = REG_WR && REG_ADDR == RCDC_ADDR_QCTL;
   assign cal_start = s_reg.cal_pend & ~s_reg.qctl_hi[RCDC_CALDIS_BIT-5];  // see R7

   rcdc_qclk_cal u_cal (
      .clk       (CORE_CLK),
      .rst       (RST),
      .iclk_pin  (ICLK_IN),
      .cal_start (cal_start),
      .taps      (s_reg.taps),
      .iclk      (iclk),
      .qclk      (qclk),
      .half_turn (half_turn),
      .cal_done  (cal_done),
      .cal_taps  (cal_taps)
   );

   always_comb begin
      s_next          = s_reg;
      s_next.aux_s1   = AUX_SERIAL_IN;
      s_next.aux_s2   = s_reg.aux_s1;
      s_next.cal_pend = RX_FRAME_END;  // see R7
      // Register writes; reserved bits are stored as written
      if (REG_WR) begin
         if (REG_ADDR == RCDC_ADDR_PRESET) begin
            s_next.preset = REG_WDATA;  // see R11
         end else if (REG_ADDR == RCDC_ADDR_RXCTL) begin
            s_next.rxctl = REG_WDATA;  // see R10
         end else if (REG_ADDR == RCDC_ADDR_QCTL) begin
            s_next.qctl_hi = REG_WDATA[RCDC_CALDIS_BIT:RCDC_QRSV_BIT];
         end
      end
      // Host write beats a calibration result landing in the same cycle
      if (wr_qctl) begin
         s_next.taps = REG_WDATA[RCDC_TAPS_MSB:0];  // see R9
      end else if (cal_done) begin
         s_next.taps = cal_taps;  // see R9
      end
      s_next.rdata = 8'h00;
      if (REG_RD) begin
         if (REG_ADDR == RCDC_ADDR_PRESET) begin
            s_next.rdata = s_reg.preset;
         end else if (REG_ADDR == RCDC_ADDR_RXCTL) begin
            s_next.rdata = s_reg.rxctl;
         end else if (REG_ADDR == RCDC_ADDR_QCTL) begin
            s_next.rdata = qctl_view(half_turn, s_reg.qctl_hi, s_reg.taps);  // see R8
         end
      end
      // Guard sequencing; a new transmission restarts the guard
      case (s_reg.rx_st)
         RX_IDLE, RX_RECV: begin
            if (TX_DONE) begin
               s_next.guard_cnt = GUARD_COUNT;
               s_next.rx_st     = (GUARD_COUNT == 8'h00) ? RX_RECV : RX_GUARD;  // see R13
            end else if (RX_FRAME_END) begin
               s_next.rx_st = RX_IDLE;  // see R14
            end
         end
         RX_GUARD: begin
            if (TX_DONE) begin
               s_next.guard_cnt = GUARD_COUNT;
               s_next.rx_st     = (GUARD_COUNT == 8'h00) ? RX_RECV : RX_GUARD;
            end else if (BIT_CLK_TICK) begin
               s_next.guard_cnt = s_reg.guard_cnt - 8'h01;
               if (s_reg.guard_cnt == 8'h01) begin
                  s_next.rx_st = RX_RECV;  // see R13
               end
            end
         end
         default: s_next.rx_st = RX_IDLE;
      endcase
      s_next.rx_pwr = ~s_reg.rxctl[RCDC_AUTOPD_BIT] || s_next.rx_st == RX_RECV;  // see R2, R14
      s_next.rcv_clk = s_reg.rxctl[RCDC_CLKSEL_BIT] ? iclk : qclk;  // see R1
      case (src)
         SRC_LOW:   s_next.dec_data = 1'b0;  // see R3
         SRC_DEMOD: s_next.dec_data = DEMOD_IN;  // see R3
         default:   s_next.dec_data = s_reg.aux_s2;  // see R4
      endcase
      s_next.dec_subc = (src == SRC_SUBC);  // see R4
      if (s_reg.rx_st == RX_GUARD) begin
         s_next.dec_data = 1'b0;  // see R13
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         s_reg <= '{preset: RCDC_PRESET_RST, rxctl: RCDC_RXCTL_RST, qctl_hi: RCDC_QCTL_HI_RST,
                    taps: RCDC_TAPS_RST, rx_st: RX_IDLE, guard_cnt: 8'h00, aux_s1: 1'b0,
                    aux_s2: 1'b0, cal_pend: 1'b1, rdata: 8'h00, dec_data: 1'b0,
                    dec_subc: 1'b0, rcv_clk: 1'b0, rx_pwr: 1'b0};  // see R12
      end else begin
         s_reg <= s_next;
      end
   end

   assign REG_RDATA       = s_reg.rdata;
   assign RECEIVER_CLK    = s_reg.rcv_clk;
   assign RECEIVER_POWER  = s_reg.rx_pwr;
   assign RX_ACTIVE       = s_reg.rx_st == RX_RECV;
   assign DECODER_DATA    = s_reg.dec_data;
   assign DECODER_SUBCARR = s_reg.dec_subc;

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   property p_clk_sel;
      ##1 RECEIVER_CLK == ($past(s_reg.rxctl[RCDC_CLKSEL_BIT]) ? $past(iclk) : $past(qclk));
   endproperty
   a_clk_sel: assert property (p_clk_sel)  // see R1
      else $error("receiver clock source mismatch");

   property p_pwr_on;
      !s_reg.rxctl[RCDC_AUTOPD_BIT] |=> RECEIVER_POWER;
   endproperty
   a_pwr_on: assert property (p_pwr_on)  // see R2
      else $error("receiver unpowered with auto power-down off");

   property p_src_low;
      (src == SRC_LOW) |=> !DECODER_DATA;
   endproperty
   a_src_low: assert property (p_src_low)  // see R3
      else $error("decoder input not low");

   property p_src_aux;
      (src[1] && s_reg.rx_st != RX_GUARD) |=> DECODER_DATA == $past(s_reg.aux_s2);
   endproperty
   a_src_aux: assert property (p_src_aux)  // see R4
      else $error("decoder not fed from aux pin");

   property p_cal_trig;
      (RX_FRAME_END && !s_reg.qctl_hi[RCDC_CALDIS_BIT-5] && !wr_qctl) |=> cal_start;
   endproperty
   a_cal_trig: assert property (p_cal_trig)  // see R7
      else $error("calibration not started after reception");

   property p_tap_write;
      wr_qctl |=> s_reg.taps == $past(REG_WDATA[RCDC_TAPS_MSB:0]);
   endproperty
   a_tap_write: assert property (p_tap_write)  // see R9
      else $error("tap write lost");

   property p_tap_read;
      (REG_RD && REG_ADDR == RCDC_ADDR_QCTL) |=>
         REG_RDATA == {$past(half_turn), $past(s_reg.qctl_hi), $past(s_reg.taps)};
   endproperty
   a_tap_read: assert property (p_tap_read)  // see R6
      else $error("quadrature control read mismatch");

   property p_guard;
      (TX_DONE && GUARD_COUNT != 8'h00) |=> !RX_ACTIVE ##1 !DECODER_DATA;
   endproperty
   a_guard: assert property (p_guard)  // see R13
      else $error("receive input not ignored during guard");

   property p_autopd;
      // Frame end is ignored while the guard runs, so that case is left out
      (s_reg.rxctl[RCDC_AUTOPD_BIT] && RX_FRAME_END && !TX_DONE && s_reg.rx_st != RX_GUARD)
         |=> !RECEIVER_POWER;
   endproperty
   a_autopd: assert property (p_autopd)  // see R14
      else $error("receiver still powered after frame");

   c_guard_done: cover property (s_reg.rx_st == RX_GUARD ##1 s_reg.rx_st == RX_RECV);
   c_cal_done:   cover property (cal_done);
   c_subc:       cover property (src == SRC_SUBC && RX_ACTIVE);
   c_tap_race:   cover property (wr_qctl && cal_done);
endmodule

// File: testbench/rcdc_host_model.sv
// Host model driving the register strobes of the receive clock/decoder block
`timescale 1ns/1ns
module rcdc_host_model
   import rcdc_pkg::*;
(
   input  wire logic       CORE_CLK,  // Core clock
   output logic      [5:0] REG_ADDR,  // Register address
   output logic      [7:0] REG_WDATA, // Write data
   output logic            REG_WR,    // Write strobe
   output logic            REG_RD,    // Read strobe
   input  wire logic [7:0] REG_RDATA  // Read data
);
   logic [7:0] rx_shadow;
   logic [7:0] q_shadow;
   initial begin
      REG_ADDR = 6'h00;
      REG_WDATA = 8'h00;
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      rx_shadow = RCDC_RXCTL_RST;
      q_shadow = 8'h00;
   end
   // Reserved bits always go back as last seen, whatever the caller passes
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a == RCDC_ADDR_PRESET) return;
      if (a == RCDC_ADDR_RXCTL) v = {d[7:6], rx_shadow[5:2], d[1:0]};
      if (a == RCDC_ADDR_QCTL) v = {d[7:6], q_shadow[5], d[4:0]};
      if (a == RCDC_ADDR_RXCTL) rx_shadow = v;
      if (a == RCDC_ADDR_QCTL) q_shadow = v;
      @(negedge CORE_CLK);
      REG_ADDR = a;
      REG_WDATA = v;
      REG_WR = 1'b1;
      @(negedge CORE_CLK);
      REG_WR = 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(negedge CORE_CLK);
      REG_ADDR = a;
      REG_RD = 1'b1;
      @(negedge CORE_CLK);
      REG_RD = 1'b0;
      d = REG_RDATA;
   endtask
endmodule

// File: testbench/rcdc_top_test.sv
// Self-checking bench for the receive clock/decoder register block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
   $display("BAD %s exp %0h got %0h", nm, e, g); end end
module rcdc_top_test
   import rcdc_pkg::*;
;
   localparam int CAL_PER = 10;
   logic clk, rst, tick, txd, fend, demod, aux, iclk;
   logic [7:0] gcount, rdata, wdata;
   logic [5:0] addr;
   logic wr, rd, rclk, pwr, act, ddata, dsub, b;
   int n_fail, comparisons, taps_m, caldis_m, d1, d3, d6;

   rcdc_top uut (.CORE_CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .GUARD_COUNT(gcount),
      .BIT_CLK_TICK(tick), .TX_DONE(txd), .RX_FRAME_END(fend), .DEMOD_IN(demod),
      .AUX_SERIAL_IN(aux), .ICLK_IN(iclk), .RECEIVER_CLK(rclk), .RECEIVER_POWER(pwr),
      .RX_ACTIVE(act), .DECODER_DATA(ddata), .DECODER_SUBCARR(dsub));
   rcdc_host_model host (.CORE_CLK(clk), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Free-running in-phase clock, phase unrelated to the core clock
   initial begin
      iclk = 1'b0;
      #7;
      forever #(CAL_PER * 20) iclk = ~iclk;
   end

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk_reg(input logic [5:0] a, input logic [7:0] e);
      logic [7:0] d;
      host.rd(a, d);
      `CHK("register", e, d)
   endtask
   function automatic int cal_taps();
      int t;
      t = CAL_PER / 4;
      if (t < 1) t = 1;
      if (t > 31) t = 31;
      return t;
   endfunction
   function automatic logic [7:0] q_exp();
      return {1'(2 * taps_m > CAL_PER), 1'(caldis_m), 1'b0, 5'(taps_m)};
   endfunction
   // Cycles from an in-phase rise to the next rise of the receiver clock
   task automatic lag(output int d);
      logic prev;
      logic ip;
      int   w;
      // In-phase rise is spotted at the core clock's falling edge, bounded wait
      ip = iclk;
      for (w = 0; w < 2 * CAL_PER && !(iclk && !ip); w++) begin
         ip = iclk;
         @(negedge clk);
      end
      if (w == 2 * CAL_PER) begin
         n_fail++;
         finish_test();
      end
      prev = rclk;
      for (d = 1; d < 30; d++) begin
         @(negedge clk);
         if (!prev && rclk) break;
         prev = rclk;
      end
      if (d == 30) begin
         n_fail++;
         finish_test();
      end
   endtask
   task automatic frame(input int n, input logic apd);
      int k;
      demod = 1'b1;
      gcount = 8'(n);
      txd = 1'b1;
      cyc(1);
      txd = 1'b0;
      for (int i = 0; i < n; i++) begin
         cyc(1);
         `CHK("guard_active", 1'b0, act)
         if (i > 0) `CHK("guard_data", 1'b0, ddata)
         `CHK("guard_power", !apd, pwr)
         tick = 1'b1;
         cyc(1);
         tick = 1'b0;
      end
      for (k = 0; k < 4 && act !== 1'b1; k++) cyc(1);
      if (k == 4) begin
         n_fail++;
         finish_test();
      end
      `CHK("rx_power", 1'b1, pwr)
      cyc(1);
      `CHK("rx_data", 1'b1, ddata)
      fend = 1'b1;
      cyc(1);
      fend = 1'b0;
      cyc(1);
      `CHK("end_active", 1'b0, act)
      `CHK("end_power", !apd, pwr)
   endtask

   initial begin
      {tick, txd, fend, demod, aux, gcount} = '0;
      rst = 1'b1;
      void'($urandom(516));
      repeat (4) @(negedge clk);
      rst = 1'b0;
      chk_reg(RCDC_ADDR_PRESET, RCDC_PRESET_RST);
      chk_reg(RCDC_ADDR_RXCTL, 8'h41);
      host.wr(6'h20, 8'hFF);
      chk_reg(6'h20, 8'h00);
      chk_reg(RCDC_ADDR_RXCTL, 8'h41);
      cyc(100);
      taps_m = cal_taps();
      caldis_m = 0;
      chk_reg(RCDC_ADDR_QCTL, q_exp());
      $display("test reset and calibration done");
      for (int s = 0; s < 4; s++) begin
         for (int v = 0; v < 2; v++) begin
            b = 1'(v) ^ 1'($urandom);
            demod = b;
            aux = ~b;
            host.wr(RCDC_ADDR_RXCTL, 8'(s));
            cyc(6);
            `CHK("dec_data", (s == 0) ? 1'b0 : (s == 1) ? b : ~b, ddata)
            `CHK("dec_subc", 1'(s == 2), dsub)
         end
      end
      $display("test decoder source done");
      host.wr(RCDC_ADDR_QCTL, 8'h43);
      caldis_m = 1;
      taps_m = 3;
      chk_reg(RCDC_ADDR_QCTL, q_exp());
      host.wr(RCDC_ADDR_RXCTL, 8'h80);
      cyc(20);
      lag(d1);
      host.wr(RCDC_ADDR_RXCTL, 8'h00);
      cyc(20);
      lag(d3);
      host.wr(RCDC_ADDR_QCTL, 8'h46);
      taps_m = 6;
      chk_reg(RCDC_ADDR_QCTL, q_exp());
      cyc(20);
      lag(d6);
      `CHK("lag_step", 3, d6 - d3)
      `CHK("q_lags", 1, int'(d3 > d1))
      $display("test clock select done");
      host.wr(RCDC_ADDR_RXCTL, 8'h41);
      host.wr(RCDC_ADDR_QCTL, 8'h47);
      taps_m = 7;
      frame(1 + $urandom % 4, 1'b1);
      cyc(60);
      chk_reg(RCDC_ADDR_QCTL, q_exp());
      host.wr(RCDC_ADDR_RXCTL, 8'h01);
      host.wr(RCDC_ADDR_QCTL, 8'h07);
      caldis_m = 0;
      frame(1 + $urandom % 4, 1'b0);
      cyc(60);
      taps_m = cal_taps();
      chk_reg(RCDC_ADDR_QCTL, q_exp());
      $display("test guard and power done");
      finish_test();
   end
endmodule
